/* hdl/udrc_map.svh */
// Register offsets, field positions, reset values and timing counts of the reset controller.
`ifndef UDRC_MAP_SVH
`define UDRC_MAP_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define UDRC_PROC_CS_ADDR      16'h7F92
`define UDRC_PROC_HOLD_BIT     0
`define UDRC_CLK_OE_BIT        1
`define UDRC_PROC_CS_LOW_RST   4'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define UDRC_ZERO8_RST         8'h00
`define UDRC_USB_CS_RST        8'h04
`define UDRC_OWNERSHIP_BIT     1
`define UDRC_BULK_IN_VAL_RST   8'h57
`define UDRC_BULK_OUT_VAL_RST  8'h55
`define UDRC_ISO_VAL_RST       8'h07
`define UDRC_OUT_ARMED_CS      8'h02
`define UDRC_BREAK_BIT         3
`define UDRC_LOAD_MARKER       8'hB2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define UDRC_CLK_MHZ           100
`define UDRC_BUS_RESET_MS      10
`define UDRC_BUS_RESET_CYC     (`UDRC_BUS_RESET_MS * 1000 * `UDRC_CLK_MHZ)

`endif

/* hdl/udrc_pkg.sv */
// Types shared by the reset controller modules.
`default_nettype none
package udrc_pkg;

   typedef enum logic [1:0]
   {
      UDRC_BOOT_PROBE,
      UDRC_BOOT_LOAD,
      UDRC_BOOT_DONE
   } udrc_boot_state_t;

   // Host or processor write toward the processor control register.
   typedef struct packed
   {
      logic        valid;
      logic [15:0] addr;
      logic [7:0]  data;
   } udrc_wr_t;

   // Snapshot of the USB resources that the resets shape.
   typedef struct packed
   {
      logic [7:0] bulkInCs;
      logic [7:0] bulkOutCs;
      logic [7:0] stall;
      logic [7:0] toggle;
      logic [7:0] usb_control_status;
      logic [7:0] funcAddr;
      logic [7:0] bulkInValid;
      logic [7:0] bulkOutValid;
      logic [7:0] isoInValid;
      logic [7:0] isoOutValid;
      logic [7:0] pairing;
      logic [7:0] breakAutovec;
      logic [7:0] irqEnable;
      logic [7:0] irqPending;
      logic [7:0] portConfig;
      logic [7:0] portOe;
      logic [7:0] configSel;
      logic [7:0] altSetting;
   } udrc_state_t;

endpackage
`default_nettype wire

/* hdl/udrc_reset_sync.sv */
// Two-stage synchroniser for release of the reset pin.
`timescale 1ns/1ns
`default_nettype none

module udrc_reset_sync
(
   // Clock
   input  wire logic clk_sys,
   // Pin level, high while reset is forced
   input  wire logic resetPin,
   // Synchronised chip reset, high while active
   output var  logic chipReset
);

   logic stage1_r;

   // ------------------------------------------------------------
   // Release synchroniser
   // ------------------------------------------------------------
   // Assertion takes effect at the next edge; release waits two edges.
   always_ff @(posedge clk_sys)
   begin
      stage1_r  <= resetPin;
      chipReset <= stage1_r | resetPin;
   end

endmodule

`default_nettype wire

/* hdl/udrc_reset_control.sv */
// Reset sequencing of the USB peripheral controller.
//
// Contract
// RULE1 - Hold core in reset until PLL locks.
// RULE2 - Reset pin forces full reset; oscillator runs.
// RULE3 - Clock output runs at power and reset.
// RULE4 - Suspended after reset: clock stops until wake.
// RULE5 - Only processor clears clock output enable.
// RULE6 - Control register resets to rev and 0011.
// RULE7 - Ports reset to plain inputs.
// RULE8 - Interrupt enables and requests cleared.
// RULE9 - Endpoints unarmed; NAK while processor held.
// RULE10 - Release arms every bulk OUT endpoint; the code arms only those set in bulkOutValid.
// RULE11 - Toggles and function address cleared.
// RULE12 - USB status: ownership 0, disconnect drive 1.
// RULE13 - Endpoint valid registers load default sets.
// RULE14 - No pairing; iso zero reply cleared.
// RULE15 - Breakpoint, autovector, configuration, alternate cleared.
// RULE16 - Host writes zero to release processor.
// RULE17 - EEPROM marker load ends with release write.
// RULE18 - External code without EEPROM auto releases.
// RULE19 - Host writing one re-holds processor.
// RULE20 - Processor reset: disable interrupts, clear break.
// RULE21 - Bus reset: interrupt, unarm IN, clear state.
// RULE22 - Reset pin release synchronised to clock.
`timescale 1ns/1ns
`default_nettype none
`include "udrc_map.svh"

module udrc_reset_control
   import udrc_pkg::*;
#(
   parameter logic [3:0] REVISION      = 4'h1,   // Arbitrary value.
   parameter int         BUS_RESET_CYC = `UDRC_BUS_RESET_CYC
)
(
   // Clock and pins
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        resetPin,
   input  wire logic        pllLocked,
   input  wire logic        wakeRequestPin_b,
   input  wire logic        externalCodeSelect,
   // USB line state
   input  wire logic        suspended,
   input  wire logic        busActivity,
   input  wire logic        se0,
   // Host register writes through endpoint zero
   input  wire udrc_wr_t    hostWr,
   // Processor register writes
   input  wire udrc_wr_t    procWr,
   // Boot EEPROM loader
   input  wire logic        eepromPresent,
   input  wire logic        eepromByteValid,
   input  wire logic [7:0]  eepromByte,
   input  wire logic        eepromLast,
   // Endpoint events from the USB engine
   input  wire logic [7:0]  bulkOutArmSet,
   input  wire logic [7:0]  bulkOutDisarm,
   input  wire logic [7:0]  irqSet,
   // Outputs
   output var  logic        coreReset,
   output var  logic        procReset,
   output var  logic        clockOutputGate,
   output var  logic        nakAllBulk,
   output var  logic        busResetIrq,
   output var  logic        ramWriteEn,
   output var  logic [7:0]  ramWriteData,
   output var  logic [7:0]  procControlStatus,
   output var  udrc_state_t usbState
);

   // A zero count would raise the bus reset interrupt on the first SE0 cycle.
   if (BUS_RESET_CYC < 1)
   begin
      $error("BUS_RESET_CYC must be at least one");
   end

   logic             chipReset;
   logic             porActive;
   logic             procHold_r;
   logic             clockEnable_r;
   logic             clockStopped_r;
   logic             procHoldPrev_r;
   logic [31:0]      se0Count_r;
   logic             busResetSeen_r;
   udrc_boot_state_t bootState_r;
   logic             bootFirst_r;

   // ------------------------------------------------------------
   // Power-on reset
   // ------------------------------------------------------------
   // RULE22 synchronised release
   udrc_reset_sync u_sync
   (
      .clk_sys   (clk_sys),
      .resetPin  (resetPin),
      .chipReset (chipReset)
   );

   // RULE1 RULE2 RULE3 one reset
   // Power-up and the reset pin merge; the PLL is never reset here.
   assign porActive = !rst_b | chipReset | !pllLocked;

   function automatic logic regHit(input udrc_wr_t wr);
      return wr.valid && (wr.addr == `UDRC_PROC_CS_ADDR);
   endfunction

   // ------------------------------------------------------------
   // Boot loader
   // ------------------------------------------------------------
   // RULE17 marker detect
   always_ff @(posedge clk_sys)
   begin
      if (porActive)
      begin
         bootState_r  <= UDRC_BOOT_PROBE;
         bootFirst_r  <= 1'b1;
         ramWriteEn   <= 1'b0;
         ramWriteData <= `UDRC_ZERO8_RST;
      end
      else
      begin
         ramWriteEn   <= 1'b0;
         ramWriteData <= eepromByte;
         unique case (bootState_r)
            UDRC_BOOT_PROBE:
            begin
               if (!eepromPresent)
                  bootState_r <= UDRC_BOOT_DONE;
               else if (eepromByteValid)
               begin
                  bootFirst_r <= 1'b0;
                  bootState_r <= (eepromByte == `UDRC_LOAD_MARKER) ? UDRC_BOOT_LOAD : UDRC_BOOT_DONE;
               end
            end
            UDRC_BOOT_LOAD:
            begin
               if (eepromByteValid)
               begin
                  ramWriteEn <= !eepromLast;
                  if (eepromLast)
                     bootState_r <= UDRC_BOOT_DONE;
               end
            end
            UDRC_BOOT_DONE:
               bootFirst_r <= bootFirst_r;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Processor hold
   // ------------------------------------------------------------
   logic bootRelease;
   logic autoRelease;

   // RULE17 final write of zero
   assign bootRelease = (bootState_r == UDRC_BOOT_LOAD) && eepromByteValid && eepromLast;
   // RULE18 external code release
   assign autoRelease = (bootState_r == UDRC_BOOT_PROBE) && externalCodeSelect
                        && (!eepromPresent || (eepromByteValid && eepromByte != `UDRC_LOAD_MARKER));

   always_ff @(posedge clk_sys)
   begin
      if (porActive)
         // RULE6 hold at reset
         procHold_r <= 1'b1;
      // RULE16 RULE19 host writes
      else if (regHit(hostWr))
         procHold_r <= hostWr.data[`UDRC_PROC_HOLD_BIT];
      else if (bootRelease || autoRelease)
         procHold_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // Clock output
   // ------------------------------------------------------------
   // RULE5 processor-only enable
   always_ff @(posedge clk_sys)
   begin
      if (porActive)
         clockEnable_r <= 1'b1;
      else if (regHit(procWr))
         clockEnable_r <= procWr.data[`UDRC_CLK_OE_BIT];
   end

   // RULE4 suspend stop
   // Resume and wake take priority, so a wake is never lost to a standing suspend.
   always_ff @(posedge clk_sys)
   begin
      if (porActive)
         clockStopped_r <= 1'b0;
      else if (busActivity || !wakeRequestPin_b)
         clockStopped_r <= 1'b0;
      else if (suspended)
         clockStopped_r <= 1'b1;
   end

   // RULE3 RULE4 RULE5 gate
   always_ff @(posedge clk_sys)
   begin
      if (porActive)
         clockOutputGate <= 1'b1;
      else
         clockOutputGate <= clockEnable_r && !clockStopped_r;
   end

   // ------------------------------------------------------------
   // Bus reset detect
   // ------------------------------------------------------------
   // RULE21 SE0 timing
   // The counter saturates and busResetSeen_r stays set, so one long SE0 raises the interrupt only once.
   always_ff @(posedge clk_sys)
   begin
      if (porActive || !se0)
      begin
         se0Count_r     <= '0;
         busResetSeen_r <= 1'b0;
         busResetIrq    <= 1'b0;
      end
      else
      begin
         busResetIrq <= 1'b0;
         if (se0Count_r < 32'(BUS_RESET_CYC))
            se0Count_r <= se0Count_r + 32'd1;
         else if (!busResetSeen_r)
         begin
            busResetSeen_r <= 1'b1;
            busResetIrq    <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // USB resources
   // ------------------------------------------------------------
   logic procRelease;
   logic procEnter;
   // The previous hold starts high, so the first cycle after reset does not raise procEnter.
   assign procRelease = procHoldPrev_r && !procHold_r;
   assign procEnter   = !procHoldPrev_r && procHold_r;

   always_ff @(posedge clk_sys)
   begin
      if (porActive)
         procHoldPrev_r <= 1'b1;
      else
         procHoldPrev_r <= procHold_r;
   end

   always_ff @(posedge clk_sys)
   begin
      if (porActive)
      begin
         // RULE7 ports inputs
         usbState.portConfig   <= `UDRC_ZERO8_RST;
         usbState.portOe       <= `UDRC_ZERO8_RST;
         // RULE8 interrupts cleared
         usbState.irqEnable    <= `UDRC_ZERO8_RST;
         usbState.irqPending   <= `UDRC_ZERO8_RST;
         // RULE9 endpoints unarmed
         usbState.bulkInCs     <= `UDRC_ZERO8_RST;
         usbState.bulkOutCs    <= `UDRC_ZERO8_RST;
         usbState.stall        <= `UDRC_ZERO8_RST;
         // RULE11 toggles and address
         usbState.toggle       <= `UDRC_ZERO8_RST;
         usbState.funcAddr     <= `UDRC_ZERO8_RST;
         // RULE12 status default
         usbState.usb_control_status        <= `UDRC_USB_CS_RST;
         // RULE13 valid defaults
         usbState.bulkInValid  <= `UDRC_BULK_IN_VAL_RST;
         usbState.bulkOutValid <= `UDRC_BULK_OUT_VAL_RST;
         usbState.isoInValid   <= `UDRC_ISO_VAL_RST;
         usbState.isoOutValid  <= `UDRC_ISO_VAL_RST;
         // RULE14 no pairing
         usbState.pairing      <= `UDRC_ZERO8_RST;
         // RULE15 break and configuration
         usbState.breakAutovec <= `UDRC_ZERO8_RST;
         usbState.configSel    <= `UDRC_ZERO8_RST;
         usbState.altSetting   <= `UDRC_ZERO8_RST;
      end
      else
      begin
         // Engine events set pending bits; set wins over nothing here.
         usbState.irqPending <= usbState.irqPending | irqSet;
         usbState.bulkOutCs  <= (usbState.bulkOutCs & ~bulkOutDisarm)
                                | (bulkOutArmSet & {8{`UDRC_OUT_ARMED_CS != 8'h00}});
         // RULE18 ownership to processor
         if (autoRelease)
            usbState.usb_control_status[`UDRC_OWNERSHIP_BIT] <= 1'b1;
         // RULE20 processor reset effects
         if (procEnter)
         begin
            usbState.irqEnable                   <= `UDRC_ZERO8_RST;
            usbState.breakAutovec[`UDRC_BREAK_BIT] <= 1'b0;
         end
         // RULE9 unarmed while held
         if (procHold_r)
         begin
            usbState.bulkInCs  <= `UDRC_ZERO8_RST;
            usbState.bulkOutCs <= `UDRC_ZERO8_RST;
         end
         // RULE10 arm OUT on release
         else if (procRelease)
            usbState.bulkOutCs <= usbState.bulkOutValid;
         // RULE21 bus reset effects
         if (busResetIrq)
         begin
            usbState.irqPending[0] <= 1'b1;
            usbState.bulkInCs      <= `UDRC_ZERO8_RST;
            usbState.toggle        <= `UDRC_ZERO8_RST;
            usbState.funcAddr      <= `UDRC_ZERO8_RST;
            usbState.configSel     <= `UDRC_ZERO8_RST;
            usbState.altSetting    <= `UDRC_ZERO8_RST;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      coreReset         <= porActive;
      procReset         <= porActive | procHold_r;
      // RULE9 NAK while held
      nakAllBulk        <= porActive | procHold_r;
      // RULE6 readback
      // The reset branch stops stale hold and enable bits showing in the first reset cycle.
      if (porActive)
         procControlStatus <= {REVISION, `UDRC_PROC_CS_LOW_RST};
      else
         procControlStatus <= {REVISION, 2'b00, clockEnable_r, procHold_r};
   end

endmodule

`default_nettype wire

/* verif/udrc_reset_control_sva.sv */
// Port assertions for the reset controller.
`timescale 1ns/1ns
`default_nettype none
`include "udrc_map.svh"

module udrc_reset_control_sva
   import udrc_pkg::*;
#(
   parameter logic [3:0] REVISION      = 4'h1,
   parameter int         BUS_RESET_CYC = 20
)
(
   // Clock and pins
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        resetPin,
   input  wire logic        pllLocked,
   input  wire logic        se0,
   input  wire udrc_wr_t    hostWr,
   // Outputs
   input  wire logic        coreReset,
   input  wire logic        procReset,
   input  wire logic        nakAllBulk,
   input  wire logic        clockOutputGate,
   input  wire logic        busResetIrq,
   input  wire logic [7:0]  procControlStatus,
   input  wire udrc_state_t usbState
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // The held core masks host writes, so they are left out.
   sequence s_hw(d);
      hostWr.valid && hostWr.addr == `UDRC_PROC_CS_ADDR && hostWr.data[0] == d && !coreReset;
   endsequence
   sequence s_held2;
      coreReset ##1 coreReset;
   endsequence

   property p_pll; !pllLocked |=> coreReset; endproperty
   a_pll: assert property (p_pll) else $error("core left running without lock");
   property p_pin; resetPin [*2] |=> coreReset; endproperty
   a_pin: assert property (p_pin) else $error("reset pin did not reset core");
   property p_sync; $fell(resetPin) |-> s_held2; endproperty
   a_sync: assert property (p_sync) else $error("reset release not synchronised");
   property p_por;
      coreReset |-> procControlStatus == {REVISION, 4'h3} && procReset && nakAllBulk && clockOutputGate;
   endproperty
   a_por: assert property (p_por) else $error("control register not at reset value");
   property p_def;
      coreReset |-> usbState.usb_control_status == 8'h04 && usbState.bulkInValid == 8'h57
         && usbState.bulkOutValid == 8'h55 && usbState.isoOutValid == 8'h07 && usbState.irqPending == 8'h00;
   endproperty
   a_def: assert property (p_def) else $error("resource defaults wrong");
   property p_rel; s_hw(1'b0) |-> ##2 !procReset && !nakAllBulk; endproperty
   a_rel: assert property (p_rel) else $error("host zero did not release");
   property p_hold; s_hw(1'b1) |-> ##2 procReset && nakAllBulk; endproperty
   a_hold: assert property (p_hold) else $error("host one did not hold");
   property p_arm; $fell(procReset) |-> usbState.bulkOutCs == usbState.bulkOutValid; endproperty
   a_arm: assert property (p_arm) else $error("OUT endpoints not armed");
   property p_clk; hostWr.valid && procControlStatus[1] |-> ##2 procControlStatus[1]; endproperty
   a_clk: assert property (p_clk) else $error("host changed clock enable");
   property p_bus;
      busResetIrq |-> $past(se0) ##1 (usbState.funcAddr | usbState.toggle | usbState.bulkInCs) == 8'h00;
   endproperty
   a_bus: assert property (p_bus) else $error("bus reset effects wrong");
endmodule

bind udrc_reset_control udrc_reset_control_sva #(.REVISION(REVISION), .BUS_RESET_CYC(BUS_RESET_CYC)) u_sva
   (.clk_sys, .rst_b, .resetPin, .pllLocked, .se0, .hostWr, .coreReset, .procReset, .nakAllBulk,
    .clockOutputGate, .busResetIrq, .procControlStatus, .usbState);
`default_nettype wire

/* verif/udrc_eeprom_model.sv */
// Boot memory model that streams a load image once started.
`timescale 1ns/1ns
`default_nettype none

module udrc_eeprom_model
(
   // Control
   input  wire logic       clk_sys,
   input  wire logic       start,
   input  wire logic [7:0] marker,
   // Loader side
   output var  logic       present,
   output var  logic       byteValid,
   output var  logic [7:0] byteOut,
   output var  logic       last
);
   // ------------------------------------------------------------
   // Stream
   // ------------------------------------------------------------
   logic [3:0] cnt;

   initial
   begin
      cnt = 4'h0; present = 1'b0; byteValid = 1'b0; byteOut = 8'h00; last = 1'b0;
   end

   // The first byte waits eight cycles so that it lands after reset release.
   always @(posedge clk_sys)
   begin
      present   <= present | start;
      byteValid <= 1'b0;
      last      <= 1'b0;
      // Data not qualified by a strobe keeps moving.
      byteOut   <= ~byteOut;
      cnt       <= start ? 4'h1 : (cnt != 4'h0 ? cnt + 4'h1 : cnt);
      if (cnt[3] && !cnt[0])
      begin
         byteValid <= 1'b1;
         last      <= cnt == 4'hE;
         byteOut   <= cnt == 4'h8 ? marker : (cnt == 4'hE ? 8'h00 : {cnt, ~cnt});
      end
   end
endmodule
`default_nettype wire

/* verif/udrc_reset_control_tb.sv */
// Self-checking testbench of the reset controller.
`timescale 1ns/1ns
`default_nettype none
`include "udrc_map.svh"

module udrc_reset_control_tb
   import udrc_pkg::*;
();
   logic        clk_sys = 0, rst_b = 0, resetPin = 0, pllLocked = 1, wakeRequestPin_b = 1;
   logic        externalCodeSelect = 0, suspended = 0, busActivity = 0, se0 = 0, eeStart = 0;
   udrc_wr_t    hostWr = '0, procWr = '0;
   logic        eepromPresent, eepromByteValid, eepromLast;
   logic [7:0]  eepromByte, irqSet = 8'h00, ramWriteData, procControlStatus, lastRam;
   logic        coreReset, procReset, clockOutputGate, nakAllBulk, busResetIrq, ramWriteEn;
   udrc_state_t usbState;
   int          miscompares = 0, compares = 0, cyc = 0, n;

   udrc_reset_control #(.BUS_RESET_CYC(20)) DUT (.bulkOutArmSet(8'h00), .bulkOutDisarm(8'h00), .*);
   udrc_eeprom_model u_ee (.clk_sys(clk_sys), .start(eeStart), .marker(`UDRC_LOAD_MARKER),
      .present(eepromPresent), .byteValid(eepromByteValid), .byteOut(eepromByte), .last(eepromLast));

   always #5 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge clk_sys);
   endtask

   task automatic reset_dut(input logic ee);
      rst_b = 0;
      eeStart = ee;
      tick(1);
      eeStart = 0;
      tick(1);
      rst_b = 1;
      tick(3);
   endtask

   // The answer lands one edge after the write edge; the task waits two.
   task automatic wr(input logic host, input logic [7:0] d);
      if (host)
         hostWr = '{1'b1, `UDRC_PROC_CS_ADDR, d};
      else
         procWr = '{1'b1, `UDRC_PROC_CS_ADDR, d};
      tick(1);
      hostWr.valid = 0;
      procWr.valid = 0;
      tick(2);
   endtask

   task automatic t_por;
      reset_dut(0);
      chk("status", 8'h13, procControlStatus);
      chk("held", 1, procReset & nakAllBulk & clockOutputGate);
      chk("ports", 0, usbState.portConfig | usbState.portOe);
      chk("irq", 0, usbState.irqEnable | usbState.irqPending);
      chk("epCs", 0, usbState.bulkInCs | usbState.bulkOutCs | usbState.stall);
      chk("togAddr", 0, usbState.toggle | usbState.funcAddr);
      chk("usb_control_status", 8'h04, usbState.usb_control_status);
      chk("inVal", 8'h57, usbState.bulkInValid);
      chk("outVal", 8'h55, usbState.bulkOutValid);
      chk("isoVal", 8'h07, usbState.isoInValid & usbState.isoOutValid);
      chk("pair", 0, usbState.pairing);
      chk("bav", 0, usbState.breakAutovec | usbState.configSel | usbState.altSetting);
   endtask

   task automatic t_run;
      wr(1, 8'h00);
      chk("release", 0, procReset | nakAllBulk);
      chk("outArm", 8'h55, usbState.bulkOutCs);
      chk("hostZero", 8'h12, procControlStatus);
      wr(0, 8'h00);
      chk("clkOff", 8'h10, {procControlStatus[7:1], clockOutputGate});
      wr(0, 8'h02);
      irqSet = 8'h10;
      tick(1);
      irqSet = 8'h00;
      wr(1, 8'h01);
      chk("rehold", 1, procReset & nakAllBulk);
      chk("pending", 8'h10, usbState.irqPending);
      chk("keep", 8'h55, usbState.bulkOutValid);
      wr(1, 8'h00);
   endtask

   task automatic t_bus;
      se0 = 1;
      n = 0;
      while (busResetIrq !== 1'b1 && n < 60)
      begin
         tick(1);
         n++;
      end
      se0 = 0;
      chk("busDelay", 1, n >= 20 && n < 60);
      tick(1);
      chk("busState", 0, usbState.funcAddr | usbState.toggle | usbState.bulkInCs);
      chk("busIrq", 8'h11, usbState.irqPending);
   endtask

   task automatic t_pin;
      suspended = 1;
      resetPin = 1;
      tick(3);
      chk("pinHeld", 1, coreReset & clockOutputGate);
      resetPin = 0;
      pllLocked = 0;
      tick(4);
      chk("pll", 1, coreReset);
      pllLocked = 1;
      tick(4);
      chk("pinPor", 8'h13, procControlStatus);
      chk("suspStop", 0, clockOutputGate);
      wakeRequestPin_b = 0;
      tick(2);
      chk("wake", 1, clockOutputGate);
      wakeRequestPin_b = 1;
      suspended = 0;
   endtask

   task automatic t_boot;
      externalCodeSelect = 1;
      reset_dut(0);
      tick(2);
      chk("extRel", 0, procReset);
      chk("extOwn", 8'h06, usbState.usb_control_status);
      externalCodeSelect = 0;
      reset_dut(1);
      n = 0;
      while (procReset !== 1'b0 && cyc < 4000)
      begin
         tick(1);
         n += ramWriteEn;
         if (ramWriteEn)
            lastRam = ramWriteData;
      end
      chk("ramWrites", 2, n);
      chk("ramLast", 8'hC3, lastRam);
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         stop_test();
      end
   end

   initial
   begin
      t_por();
      t_run();
      t_bus();
      t_pin();
      t_boot();
      stop_test();
   end
endmodule
`default_nettype wire
